// ---- logic/pdct_params.svh ----
`ifndef PDCT_PARAMS_SVH
`define PDCT_PARAMS_SVH

// Overview of operation
// - Count value steps down once per rising edge of the tap; software loads and reads it.
// - Count stepping down to zero sets the zero-reached flag in the control/status register.
// - Flag and interrupt enable both set raise the request on shared vector 4.
// - A timer request must be able to wake the core from its wait state.
// - Prescaler input is the clock divided by twelve or the external timer pin.
// - The 7-bit prescaler counts downward on each rising edge of its input.
// - Tap select: factor 1 is the prescaler input, factor 2^n is prescaler bit n-1.
// - Prescaler and count advance only while the run bit is one.
// - Run bit zero forces all prescaler bits to one and holds the count.
// - Software may load the prescaler with 00h to 7Fh only while run is one.
// - Software reads the live prescaler state through its own register.
// - Direction and latch bits select external clock, gated clock or pin output.
// - Both mode bits zero: pin rising edges step the prescaler; pin rate at most fosc/8.
// - Gated mode: prescaler steps at clock over twelve only while the pin is high.
// - Output mode: pin driven from the latch bit, prescaler runs at clock over twelve.

// ---------------------------------------------------------------------------
// Data space offsets
// ---------------------------------------------------------------------------
`define PDCT_ADDR_PRESC 8'hd2
`define PDCT_ADDR_COUNT 8'hd3
`define PDCT_ADDR_CTRL 8'hd4

// ---------------------------------------------------------------------------
// Control/status field positions
// ---------------------------------------------------------------------------
`define PDCT_BIT_ZERO 7
`define PDCT_BIT_IRQEN 6
`define PDCT_BIT_PINDIR 5
`define PDCT_BIT_PINLATCH 4
`define PDCT_BIT_RUN 3
`define PDCT_TAP_MSB 2
`define PDCT_TAP_LSB 0

// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define PDCT_PRESC_ONES 7'h7f
`define PDCT_RST_COUNT 8'hff
`define PDCT_RST_CTRL 8'h00
`define PDCT_OSC_DIV 12

`endif

// ---- logic/pdct_pkg.sv ----
package pdct_pkg;

   // Operating mode of the timer pin, one-hot.
   typedef enum logic [2:0] {
      pdct_mode_ext = 3'h1,
      pdct_mode_gated = 3'h2,
      pdct_mode_out = 3'h4
   } pdct_mode_t;

   // Whole state of the timer.
   typedef struct packed {
      logic [6:0] presc;
      logic [7:0] count;
      logic zero_reached_flag;
      logic zero_irq_enable;
      logic pin_direction_select;
      logic pin_output_latch;
      logic prescaler_run;
      logic [2:0] tap_select;
      logic pin_prev;
      logic irq;
      logic [7:0] rd_data;
      logic pin_out;
      logic pin_oe;
   } pdct_state_t;

   // Whole state of the clock divider.
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } pdct_div_state_t;

endpackage

// ---- logic/pdct_osc_div.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pdct_params.svh"

module pdct_osc_div #(
   parameter int unsigned DIV = `PDCT_OSC_DIV
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // One-cycle enable at the divided rate.
   output logic tick_r
);
   import pdct_pkg::*;

   localparam logic [7:0] LAST = 8'(DIV - 1);

   pdct_div_state_t st_r;
   pdct_div_state_t st_nxt;

   // Free-running divider; it never stops so the tick phase is independent of mode changes.
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'h0;
      if (st_r.cnt == LAST) begin
         st_nxt.cnt = 8'h00;
         st_nxt.tick = 1'h1;
      end else begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_r = st_r.tick;

endmodule // pdct_osc_div
`default_nettype wire

// ---- logic/pdct_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pdct_params.svh"

module pdct_timer (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Data space access.
   input wire logic [7:0] ds_addr,
   input wire logic ds_wr_en,
   input wire logic ds_rd_en,
   input wire logic [7:0] ds_wr_data,
   output logic [7:0] ds_rd_data_r,
   // Timer pin.
   input wire logic timer_pin_in,
   output logic timer_pin_out_r,
   output logic timer_pin_oe_r,
   // Request on shared vector 4, also the wake-up source.
   output logic irq_vec4_r
);
   import pdct_pkg::*;

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------

   // Mode decode, used by the step logic; the checks test the mode bits directly.
   function automatic pdct_mode_t mode_of(input logic dir, input logic latch);
      if (dir) begin
         return pdct_mode_out;
      end else if (latch) begin
         return pdct_mode_gated;
      end
      return pdct_mode_ext;
   endfunction

   // Rising edge on the selected tap when the prescaler steps from old_v to new_v.
   function automatic logic tap_edge(input logic [6:0] old_v, input logic [6:0] new_v,
                                     input logic [2:0] sel);
      logic [2:0] idx;
      idx = sel - 3'h1;
      if (sel == 3'h0) begin
         return 1'h1;
      end
      return !old_v[idx] && new_v[idx];
   endfunction

   // Packs the control/status fields into the register image.
   function automatic logic [7:0] ctrl_pack(input pdct_state_t s);
      logic [7:0] v;
      v = `PDCT_RST_CTRL;
      v[`PDCT_BIT_ZERO] = s.zero_reached_flag;
      v[`PDCT_BIT_IRQEN] = s.zero_irq_enable;
      v[`PDCT_BIT_PINDIR] = s.pin_direction_select;
      v[`PDCT_BIT_PINLATCH] = s.pin_output_latch;
      v[`PDCT_BIT_RUN] = s.prescaler_run;
      v[`PDCT_TAP_MSB:`PDCT_TAP_LSB] = s.tap_select;
      return v;
   endfunction

   // ------------------------------------------------------------------------
   // Divider and access decode
   // ------------------------------------------------------------------------

   pdct_state_t st_r;
   pdct_state_t st_nxt;
   logic div_tick;
   logic wr_presc;
   logic wr_count;
   logic wr_ctrl;
   logic presc_step;
   logic count_step;
   logic [6:0] presc_dec;

   pdct_osc_div #(
      .DIV(`PDCT_OSC_DIV)
   ) u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick_r(div_tick)
   );

   // Writes are single-cycle strobes qualified by the address.
   assign wr_presc = ds_wr_en && (ds_addr == `PDCT_ADDR_PRESC);
   assign wr_count = ds_wr_en && (ds_addr == `PDCT_ADDR_COUNT);
   assign wr_ctrl = ds_wr_en && (ds_addr == `PDCT_ADDR_CTRL);
   assign presc_dec = st_r.presc - 7'h01;

   // Prescaler input selection; every source is an enable, so only one clock is used.
   always_comb begin
      presc_step = 1'h0;
      case (mode_of(st_r.pin_direction_select, st_r.pin_output_latch))
         pdct_mode_ext: begin
            presc_step = timer_pin_in && !st_r.pin_prev;
         end
         pdct_mode_gated: begin
            presc_step = div_tick && timer_pin_in;
         end
         pdct_mode_out: begin
            presc_step = div_tick;
         end
         default: begin
            presc_step = 1'h0;
         end
      endcase
      presc_step = presc_step && st_r.prescaler_run;
   end

   // The counter steps on a rising edge of the chosen tap of the downward prescaler.
   assign count_step = presc_step &&
                       tap_edge(st_r.presc, presc_dec, st_r.tap_select);

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------

   // A software count write wins over a simultaneous step, so a loaded value is never
   // skipped by one; the hardware flag set wins over a software clear.
   always_comb begin
      st_nxt = st_r;
      if (!st_r.prescaler_run) begin
         st_nxt.presc = `PDCT_PRESC_ONES;
      end else if (wr_presc) begin
         st_nxt.presc = ds_wr_data[6:0];
      end else if (presc_step) begin
         st_nxt.presc = presc_dec;
      end
      if (wr_count) begin
         st_nxt.count = ds_wr_data;
      end else if (count_step) begin
         st_nxt.count = st_r.count - 8'h01;
      end
      if (wr_ctrl) begin
         st_nxt.zero_reached_flag = st_r.zero_reached_flag &&
                                    ds_wr_data[`PDCT_BIT_ZERO];
         st_nxt.zero_irq_enable = ds_wr_data[`PDCT_BIT_IRQEN];
         st_nxt.pin_direction_select = ds_wr_data[`PDCT_BIT_PINDIR];
         st_nxt.pin_output_latch = ds_wr_data[`PDCT_BIT_PINLATCH];
         st_nxt.prescaler_run = ds_wr_data[`PDCT_BIT_RUN];
         st_nxt.tap_select = ds_wr_data[`PDCT_TAP_MSB:`PDCT_TAP_LSB];
      end
      if (!wr_count && count_step && (st_r.count == 8'h01)) begin
         st_nxt.zero_reached_flag = 1'h1;
      end
      st_nxt.pin_prev = timer_pin_in;
      // The request is a level; it doubles as the wake-up from wait state.
      st_nxt.irq = st_nxt.zero_reached_flag && st_nxt.zero_irq_enable;
      st_nxt.pin_oe = st_nxt.pin_direction_select;
      st_nxt.pin_out = st_nxt.pin_direction_select && st_nxt.pin_output_latch;
      if (ds_rd_en) begin
         case (ds_addr)
            `PDCT_ADDR_PRESC: st_nxt.rd_data = {1'h0, st_r.presc};
            `PDCT_ADDR_COUNT: st_nxt.rd_data = st_r.count;
            `PDCT_ADDR_CTRL: st_nxt.rd_data = ctrl_pack(st_r);
            default: st_nxt.rd_data = 8'h00;
         endcase
      end
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.presc <= `PDCT_PRESC_ONES;
         st_r.count <= `PDCT_RST_COUNT;
         // The pin idles high on its pull-up, so the edge detector starts high and no false
         // edge follows reset.
         st_r.pin_prev <= 1'h1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ds_rd_data_r = st_r.rd_data;
   assign timer_pin_out_r = st_r.pin_out;
   assign timer_pin_oe_r = st_r.pin_oe;
   assign irq_vec4_r = st_r.irq;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_stopped;
      !st_r.prescaler_run && !wr_count;
   endsequence

   sequence s_last_step;
      count_step && !wr_count && (st_r.count == 8'h01);
   endsequence

   sequence s_ext_edge;
      st_r.prescaler_run && !wr_presc && !st_r.pin_direction_select &&
         !st_r.pin_output_latch && timer_pin_in && !st_r.pin_prev;
   endsequence

   a_stop_forces_ones: assert property (
      !st_r.prescaler_run |=> st_r.presc == `PDCT_PRESC_ONES)
      else $error("prescaler not forced to all ones while stopped");
   a_stop_holds_count: assert property (s_stopped |=> $stable(st_r.count))
      else $error("count moved while prescaler stopped");
   a_zero_sets_flag: assert property (
      s_last_step |=> st_r.zero_reached_flag && (irq_vec4_r == st_r.zero_irq_enable))
      else $error("zero flag not set after count reached zero");
   a_flag_sticky: assert property (
      st_r.zero_reached_flag && !(wr_ctrl && !ds_wr_data[`PDCT_BIT_ZERO])
         |=> st_r.zero_reached_flag)
      else $error("zero flag cleared without a software write of zero");
   a_irq_level: assert property (
      irq_vec4_r == (st_r.zero_reached_flag && st_r.zero_irq_enable))
      else $error("interrupt request does not follow flag and enable");
   a_ext_clock_step: assert property (
      s_ext_edge |=> st_r.presc == $past(st_r.presc) - 7'h01)
      else $error("pin rising edge did not step the prescaler");
   a_presc_load: assert property (
      wr_presc && st_r.prescaler_run |=> st_r.presc == $past(ds_wr_data[6:0]))
      else $error("prescaler write while running not taken");
   a_count_load: assert property (wr_count |=> st_r.count == $past(ds_wr_data))
      else $error("count write not taken");
   a_pin_output: assert property (
      st_r.pin_direction_select |-> timer_pin_oe_r && (timer_pin_out_r == st_r.pin_output_latch))
      else $error("pin not driven from latch in output mode");
   a_read_presc: assert property (
      ds_rd_en && (ds_addr == `PDCT_ADDR_PRESC) |=> ds_rd_data_r == {1'h0, $past(st_r.presc)})
      else $error("prescaler read returns wrong value");
   a_gated_hold: assert property (
      st_r.pin_output_latch && !st_r.pin_direction_select && !timer_pin_in && !wr_presc &&
         st_r.prescaler_run |=> $stable(st_r.presc))
      else $error("gated prescaler moved with pin low");

endmodule // pdct_timer
`default_nettype wire

// ---- verification/pdct_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module pdct_pin_model (
   // Clock.
   input wire logic sys_clk,
   // Pin drive from the timer.
   input wire logic pin_out,
   input wire logic pin_oe,
   // Level seen at the pin.
   output logic pin_level
);
   logic src_r = 1'b1;

   // The pull-up keeps the line high while undriven; the timer wins when it drives.
   assign pin_level = pin_oe ? pin_out : src_r;

   // Eight clocks per period keep the pin at an eighth of the clock rate; every change
   // is made on a rising edge so the timer never sees a half-cycle level.
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         src_r <= 1'b0;
         repeat (4) @(posedge sys_clk);
         src_r <= 1'b1;
         repeat (3) @(posedge sys_clk);
      end
   endtask

   // Holds the line at a level, used for the gate.
   task automatic level(input logic v);
      src_r <= v;
   endtask
endmodule // pdct_pin_model

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pdct_params.svh"

module testbench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] ds_addr = 8'h00;
   logic ds_wr_en = 1'b0;
   logic ds_rd_en = 1'b0;
   logic [7:0] ds_wr_data = 8'h00;
   logic [7:0] ds_rd_data_r;
   logic timer_pin_in;
   logic timer_pin_out_r;
   logic timer_pin_oe_r;
   logic irq_vec4_r;
   int miscompares = 0;
   int samples_checked = 0;
   logic [6:0] exp_p;

   pdct_timer i_dut (.sys_clk(sys_clk), .rst(rst), .ds_addr(ds_addr), .ds_wr_en(ds_wr_en),
      .ds_rd_en(ds_rd_en), .ds_wr_data(ds_wr_data), .ds_rd_data_r(ds_rd_data_r),
      .timer_pin_in(timer_pin_in), .timer_pin_out_r(timer_pin_out_r),
      .timer_pin_oe_r(timer_pin_oe_r), .irq_vec4_r(irq_vec4_r));
   pdct_pin_model i_pin (.sys_clk(sys_clk), .pin_out(timer_pin_out_r),
      .pin_oe(timer_pin_oe_r), .pin_level(timer_pin_in));

   // ------------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      ds_addr <= a;
      ds_wr_data <= d;
      ds_wr_en <= 1'b1;
      @(posedge sys_clk);
      ds_wr_en <= 1'b0;
   endtask

   // Read data is registered, so it is compared just after the following edge.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      ds_addr <= a;
      ds_rd_en <= 1'b1;
      @(posedge sys_clk);
      ds_rd_en <= 1'b0;
      #1;
      chk(ds_rd_data_r, exp);
   endtask

   function automatic logic [7:0] ctl(input logic ien, input logic dir, input logic lat,
                                      input logic run, input logic [2:0] tap);
      ctl = 8'h00;
      ctl[`PDCT_BIT_IRQEN] = ien;
      ctl[`PDCT_BIT_PINDIR] = dir;
      ctl[`PDCT_BIT_PINLATCH] = lat;
      ctl[`PDCT_BIT_RUN] = run;
      ctl[`PDCT_TAP_MSB:`PDCT_TAP_LSB] = tap;
   endfunction

   task automatic test_done;
      $display("checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------------
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // The whole run needs some two and a half thousand cycles; thirty thousand means a hang.
   initial begin
      #300000;
      miscompares++;
      test_done();
   end

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      // Reset values, then an unmapped place that reads zero.
      rd(`PDCT_ADDR_PRESC, 8'h7f);
      rd(`PDCT_ADDR_COUNT, 8'hff);
      rd(`PDCT_ADDR_CTRL, 8'h00);
      rd(8'hd5, 8'h00);
      // A stopped prescaler refuses loads; a running one takes seven bits.
      wr(`PDCT_ADDR_PRESC, 8'h10);
      rd(`PDCT_ADDR_PRESC, 8'h7f);
      wr(`PDCT_ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
      wr(`PDCT_ADDR_PRESC, 8'h85);
      rd(`PDCT_ADDR_PRESC, 8'h05);
      // Stopped output mode holds the count and drives the latch out.
      wr(`PDCT_ADDR_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 3'h0));
      wr(`PDCT_ADDR_COUNT, 8'h20);
      repeat (48) @(posedge sys_clk);
      rd(`PDCT_ADDR_COUNT, 8'h20);
      chk({6'h00, timer_pin_oe_r, timer_pin_out_r}, 8'h03);
      // Running output mode reaches zero; the flag rises but stays masked.
      wr(`PDCT_ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1, 3'h0));
      wr(`PDCT_ADDR_COUNT, 8'h03);
      repeat (40) @(posedge sys_clk);
      chk({6'h00, timer_pin_oe_r, timer_pin_out_r}, 8'h02);
      chk({7'h00, irq_vec4_r}, 8'h00);
      rd(`PDCT_ADDR_CTRL, 8'h80 | ctl(1'b0, 1'b1, 1'b0, 1'b1, 3'h0));
      // Unmasking a held flag raises the request; writing zero drops it.
      wr(`PDCT_ADDR_CTRL, 8'h80 | ctl(1'b1, 1'b1, 1'b0, 1'b1, 3'h0));
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq_vec4_r}, 8'h01);
      rd(`PDCT_ADDR_CTRL, 8'h80 | ctl(1'b1, 1'b1, 1'b0, 1'b1, 3'h0));
      wr(`PDCT_ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b1, 3'h0));
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq_vec4_r}, 8'h00);
      // Each tap needs exactly two to the n pin edges per count step.
      for (int n = 0; n < 8; n++) begin
         wr(`PDCT_ADDR_CTRL, 8'h00);
         wr(`PDCT_ADDR_COUNT, 8'h40);
         wr(`PDCT_ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 3'(n)));
         i_pin.pulses((1 << n) - 1);
         rd(`PDCT_ADDR_COUNT, 8'h40);
         i_pin.pulses(1);
         rd(`PDCT_ADDR_COUNT, 8'h3f);
         exp_p = 7'h7f - 7'(1 << n);
         rd(`PDCT_ADDR_PRESC, {1'b0, exp_p});
      end
      // Gated mode counts divided clock only while the pin is high.
      wr(`PDCT_ADDR_CTRL, 8'h00);
      wr(`PDCT_ADDR_COUNT, 8'h50);
      i_pin.level(1'b0);
      wr(`PDCT_ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, 3'h0));
      repeat (48) @(posedge sys_clk);
      rd(`PDCT_ADDR_PRESC, 8'h7f);
      @(posedge sys_clk);
      i_pin.level(1'b1);
      repeat (120) @(posedge sys_clk);
      i_pin.level(1'b0);
      rd(`PDCT_ADDR_PRESC, 8'h75);
      rd(`PDCT_ADDR_COUNT, 8'h46);
      chk({7'h00, timer_pin_oe_r}, 8'h00);
      test_done();
   end
endmodule // testbench

`default_nettype wire
